/* File: common/ids_pkg.sv */
// Purpose: shared constants and types of the input debounce serializer
// Assumes: ref_clk at 20 MHz, time base tick of 1 us
// Notes:   all timers count time base ticks, not clock cycles
package ids_pkg;

	// ------------------------------------------------------------------
	// clock and time base
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK_NS       = 1000;
	localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
	localparam int TICK_W        = 5;
	localparam int TICKS_PER_MS  = 1000000 / TICK_NS;

	// ------------------------------------------------------------------
	// intervals, as printed, and their tick counts
	// ------------------------------------------------------------------
	localparam int DEB_SHORT_MS    = 1;
	localparam int DEB_LONG_MS     = 3;
	localparam int SUP_FALL_MS     = 1;
	localparam int SUP_RISE_MS     = 6;
	localparam int DEB_SHORT_TICKS = DEB_SHORT_MS * TICKS_PER_MS;
	localparam int DEB_LONG_TICKS  = DEB_LONG_MS * TICKS_PER_MS;
	localparam int SUP_FALL_TICKS  = SUP_FALL_MS * TICKS_PER_MS;
	localparam int SUP_RISE_TICKS  = SUP_RISE_MS * TICKS_PER_MS;
	localparam int TMR_W           = 13;

	// ------------------------------------------------------------------
	// channels, widths and reset values
	// ------------------------------------------------------------------
	localparam int NUM_CH = 8;
	localparam int SYNC_W = NUM_CH + 2 + 3 + 4;
	// idle pin levels: selects open, supply low, strobe and gate high,
	// chain input pulled high
	localparam logic [SYNC_W-1:0] SYNC_RST  = 17'h001db;
	localparam logic [NUM_CH-1:0] STAGE_RST = 8'hff;
	localparam logic              DEB_RST   = 1'h0;

	// ------------------------------------------------------------------
	// carriers and modes
	// ------------------------------------------------------------------
	typedef struct packed {
		logic captureN;
		logic serialClk;
		logic shiftGateN;
		logic chainIn;
	} ids_link_type;

	typedef struct packed {
		logic belowWarn;
		logic aboveRecover;
		logic belowDead;
	} ids_supply_type;

	typedef enum logic [1:0] {
		FLT_BYPASS = 2'h0,
		FLT_SHORT  = 2'h1,
		FLT_LONG   = 2'h2
	} ids_filter_type;

	typedef enum logic [3:0] {
		SUP_GOOD    = 4'h1,
		SUP_FALLING = 4'h2,
		SUP_LOW     = 4'h4,
		SUP_RISING  = 4'h8
	} ids_sup_state_type;

endpackage : ids_pkg

/* File: design/ids_debounce.sv */
// Purpose: one channel of the input debounce filter
// Assumes: raw is already synchronised to ref_clk
// Notes:   interval resolution is one time base tick
`timescale 1ns/100ps
module ids_debounce
	import ids_pkg::*;
(
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             resetn,
	// time base and setting
	input  wire logic             tick,
	input  wire logic             bypass,
	input  wire logic [TMR_W-1:0] limit,
	// level
	input  wire logic             raw,
	output logic                  stable
);

	logic [TMR_W-1:0] cnt;
	logic [TMR_W-1:0] next_cnt;
	logic             next_stable;

	// ------------------------------------------------------------------
	// filter
	// ------------------------------------------------------------------
	always_comb begin
		next_stable = stable;
		next_cnt    = cnt;
		if (raw == stable) begin
			// a bounce back restarts the wait
			next_cnt = '0; // RL16
		end else if (bypass) begin
			next_stable = raw; // RL2
		end else if (tick) begin
			if (cnt >= limit - TMR_W'(1)) begin
				next_stable = raw; // RL1
				next_cnt    = '0;
			end else begin
				next_cnt = cnt + TMR_W'(1); // RL16
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			stable <= DEB_RST;
			cnt    <= '0;
		end else begin
			stable <= next_stable;
			cnt    <= next_cnt;
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	a_deb_follow: assert property (@(posedge ref_clk) disable iff (!resetn)
		$changed(stable) |-> stable == $past(raw)) // RL1
		else $error("filtered level differs from raw level");

	a_deb_wait: assert property (@(posedge ref_clk) disable iff (!resetn)
		$changed(stable) && !$past(bypass) |->
		$past(tick) && $past(cnt) >= $past(limit) - TMR_W'(1)) // RL16
		else $error("filtered level changed before interval expired");

endmodule : ids_debounce

/* File: design/ids_serializer.sv */
// Purpose: eight channel debounced input serializer with supply monitor
// Assumes: all pins asynchronous to ref_clk; serial clock well below
//          ref_clk / 4 so each of its levels is seen by the sampler
// Notes:   serial clock edges are found by sampling, not used as clock
//
// Operation
// [RL1] new level valid after full debounce interval
// [RL2] select pins choose 3 ms, 1 ms, bypass
// [RL3] eight channels feed eight register stages
// [RL4] strobe low: stages load debounced inputs continuously
// [RL5] strobe high: parallel inputs ignored, data held
// [RL6] rising serial edge shifts all but last
// [RL7] last stage takes previous on falling edge
// [RL8] gate high freezes register on clock activity
// [RL9] host serial clock up to 100 MHz; sampled here on the 20 MHz ref_clk, so it must stay well below 5 MHz
// [RL10] supply below 15 V: flag low 1 ms later
// [RL11] supply recovered: flag high after 6 ms
// [RL12] below 10 V stop; above 18 V rise
// [RL13] chain input idles high, ones follow data
// [RL14] host lowers gate only with clock low
// [RL15] host gives eight clocks per chained device
// [RL16] per channel counter restarts on level change
// [RL17] reserved select combination acts as bypass
`timescale 1ns/100ps
module ids_serializer
	import ids_pkg::*;
#(
	parameter int DEB_SHORT = DEB_SHORT_TICKS,
	parameter int DEB_LONG  = DEB_LONG_TICKS,
	parameter int SUP_FALL  = SUP_FALL_TICKS,
	parameter int SUP_RISE  = SUP_RISE_TICKS
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              resetn,
	// field side
	input  wire logic [NUM_CH-1:0] fieldInputs,
	input  wire logic              filterSelLo,
	input  wire logic              filterSelHi,
	input  wire ids_supply_type    supplyLevel,
	output logic                   supplyGood,
	// serial link
	input  wire logic              captureStrobeN,
	input  wire logic              serialClk,
	input  wire logic              shiftGateN,
	input  wire logic              chainIn,
	output logic                   chainOut
);

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	logic [SYNC_W-1:0] syncMeta;
	logic [SYNC_W-1:0] syncSafe;
	logic [SYNC_W-1:0] next_syncMeta;
	logic [SYNC_W-1:0] next_syncSafe;
	logic [NUM_CH-1:0] rawSync;
	logic              selHi;
	logic              selLo;
	ids_supply_type    sup;
	ids_link_type      link;
	logic              sclkPrev;
	logic              next_sclkPrev;
	logic              sclkRise;
	logic              sclkFall;

	always_comb begin
		next_syncMeta = {fieldInputs, filterSelHi, filterSelLo,
			supplyLevel, captureStrobeN, serialClk, shiftGateN, chainIn};
		next_syncSafe = syncMeta;
		next_sclkPrev = link.serialClk;
	end

	// chain input resets high, as its idle pull would hold it
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			syncMeta <= SYNC_RST; // RL13
			syncSafe <= SYNC_RST;
			sclkPrev <= 1'h0;
		end else begin
			syncMeta <= next_syncMeta;
			syncSafe <= next_syncSafe;
			sclkPrev <= next_sclkPrev;
		end
	end

	assign rawSync  = syncSafe[SYNC_W-1 -: NUM_CH];
	assign selHi    = syncSafe[8];
	assign selLo    = syncSafe[7];
	assign sup      = syncSafe[6:4];
	assign link     = syncSafe[3:0];
	assign sclkRise = link.serialClk && !sclkPrev;
	assign sclkFall = !link.serialClk && sclkPrev;

	// ------------------------------------------------------------------
	// time base
	// ------------------------------------------------------------------
	logic [TICK_W-1:0] divCnt;
	logic [TICK_W-1:0] next_divCnt;
	logic              tick;

	assign tick = divCnt == TICK_W'(TICK_CYCLES - 1);

	always_comb begin
		next_divCnt = tick ? '0 : divCnt + TICK_W'(1);
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			divCnt <= '0;
		end else begin
			divCnt <= next_divCnt;
		end
	end

	// ------------------------------------------------------------------
	// debounce filters
	// ------------------------------------------------------------------
	// both selects grounded has no defined interval; bypass keeps the
	// inputs visible rather than freezing them
	function automatic ids_filter_type decodeFilter(input logic hi,
		input logic lo);
		case ({hi, lo})
			2'h3: decodeFilter = FLT_LONG;
			2'h2: decodeFilter = FLT_SHORT;
			default: decodeFilter = FLT_BYPASS; // RL17
		endcase
	endfunction : decodeFilter

	ids_filter_type    fltMode;
	logic [TMR_W-1:0]  debLimit;
	logic              bypass;
	logic [NUM_CH-1:0] debounced;
	logic [NUM_CH-1:0] loadVal;

	assign fltMode  = decodeFilter(selHi, selLo); // RL2
	assign bypass   = fltMode == FLT_BYPASS;
	assign debLimit = (fltMode == FLT_LONG) ? TMR_W'(DEB_LONG)
		: TMR_W'(DEB_SHORT); // RL2

	for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
		ids_debounce u_deb (
			.ref_clk (ref_clk),
			.resetn  (resetn),
			.tick    (tick),
			.bypass  (bypass),
			.limit   (debLimit),
			.raw     (rawSync[g]),
			.stable  (debounced[g])
		);
		// channel 0 sits next to the output and leaves first
		assign loadVal[NUM_CH-1-g] = debounced[g]; // RL3
	end

	// ------------------------------------------------------------------
	// shift register
	// ------------------------------------------------------------------
	logic [NUM_CH-1:0] stage;
	logic [NUM_CH-1:0] next_stage;
	logic              lastStage;
	logic              next_lastStage;

	// last stage is a falling edge copy of the top stage, so a rising
	// edge never overwrites a bit before it has gone out
	always_comb begin
		next_stage     = stage;
		next_lastStage = lastStage;
		if (!link.captureN) begin
			next_stage     = loadVal; // RL4
			next_lastStage = loadVal[NUM_CH-1]; // RL4
		end else if (!link.shiftGateN) begin
			if (sclkRise) begin
				next_stage = {stage[NUM_CH-2:0], link.chainIn}; // RL6
			end
			if (sclkFall) begin
				next_lastStage = stage[NUM_CH-1]; // RL7
			end
		end
		// strobe high with gate high falls through: held RL5 RL8
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			stage     <= STAGE_RST;
			lastStage <= STAGE_RST[NUM_CH-1];
		end else begin
			stage     <= next_stage;
			lastStage <= next_lastStage;
		end
	end

	assign chainOut = lastStage;

	// ------------------------------------------------------------------
	// supply monitor
	// ------------------------------------------------------------------
	ids_sup_state_type state;
	ids_sup_state_type next_state;
	logic [TMR_W-1:0]  supTicks;
	logic [TMR_W-1:0]  next_supTicks;
	logic              next_good;
	logic [TMR_W-1:0]  fallLim;
	logic [TMR_W-1:0]  riseLim;

	assign fallLim = TMR_W'(SUP_FALL);
	assign riseLim = TMR_W'(SUP_RISE);

	always_comb begin
		next_state    = state;
		next_supTicks = supTicks;
		unique case (state)
			SUP_GOOD: begin
				if (sup.belowWarn) begin
					next_state    = SUP_FALLING;
					next_supTicks = '0;
				end
			end
			SUP_FALLING: begin
				if (!sup.belowWarn) begin
					next_state = SUP_GOOD;
				end else if (tick) begin
					if (supTicks == fallLim - TMR_W'(1)) begin
						next_state = SUP_LOW; // RL10
					end
					next_supTicks = supTicks + TMR_W'(1);
				end
			end
			SUP_LOW: begin
				if (sup.aboveRecover) begin
					next_state    = SUP_RISING;
					next_supTicks = '0;
				end
			end
			SUP_RISING: begin
				if (!sup.aboveRecover) begin
					next_state = SUP_LOW;
				end else if (tick) begin
					if (supTicks == riseLim - TMR_W'(1)) begin
						next_state = SUP_GOOD; // RL11
					end
					next_supTicks = supTicks + TMR_W'(1);
				end
			end
			default: next_state = SUP_LOW;
		endcase
		// a dead supply drops the flag at once; recovery starts over
		if (sup.belowDead) begin
			next_state = SUP_LOW; // RL12
		end
		next_good = (next_state == SUP_GOOD)
			|| (next_state == SUP_FALLING);
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state      <= SUP_LOW;
			supTicks   <= '0;
			supplyGood <= 1'h0;
		end else begin
			state      <= next_state;
			supTicks   <= next_supTicks;
			supplyGood <= next_good;
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	a_load_capture: assert property ( // RL4
		!link.captureN |=> stage == $past(loadVal)
		&& chainOut == $past(loadVal[NUM_CH-1]))
		else $error("stages did not take the filtered inputs");

	a_gate_hold: assert property ( // RL8
		link.captureN && link.shiftGateN |=> $stable(stage)
		&& $stable(chainOut))
		else $error("register changed with gate high");

	a_shift_rise: assert property ( // RL6
		link.captureN && !link.shiftGateN && sclkRise |=>
		stage == {$past(stage[NUM_CH-2:0]),
		$past(link.chainIn)} && $stable(chainOut))
		else $error("rising edge shift wrong");

	a_last_fall: assert property ( // RL7
		link.captureN && !link.shiftGateN && sclkFall |=>
		chainOut == $past(stage[NUM_CH-1])
		&& $stable(stage))
		else $error("falling edge did not move last stage");

	a_sup_fall_time: assert property ( // RL10
		$fell(supplyGood) |-> $past(sup.belowDead)
		|| ($past(state) == SUP_FALLING && $past(tick)
		&& $past(supTicks) == fallLim - TMR_W'(1)))
		else $error("supply flag fell at wrong time");

	a_sup_rise_time: assert property ( // RL11
		$rose(supplyGood) |-> $past(state) == SUP_RISING
		&& $past(supTicks) == riseLim - TMR_W'(1)
		&& $past(sup.aboveRecover))
		else $error("supply flag rose at wrong time");

	a_sup_dead: assert property ( // RL12
		sup.belowDead |=> !supplyGood ##1 !supplyGood)
		else $error("supply flag high while supply dead");

	c_load: cover property (!link.captureN ##1 link.captureN);
	c_shift: cover property (!link.shiftGateN && sclkRise
		##[1:20] sclkFall);
	c_sup_fall: cover property ($fell(supplyGood));
	c_sup_rise: cover property ($rose(supplyGood));

endmodule : ids_serializer

/* File: dv/ids_host.sv */
// Purpose: host model that loads and shifts the serializer
// Assumes: serial clock of 500 ns period, held low between frames
// Notes:   also plays an upstream chained device on chainIn
`timescale 1ns/100ps
module ids_host (
	// serial link
	output logic      captureStrobeN,
	output logic      serialClk,
	output logic      shiftGateN,
	output logic      chainIn,
	input  wire logic chainOut
);
	initial begin
		captureStrobeN = 1'h1;
		serialClk      = 1'h0;
		shiftGateN     = 1'h1;
		chainIn        = 1'h1;
	end

	// optional load, then n clocks; a sample after each of the first 15 falling edges
	task automatic frame(input bit ld, input bit en, input int n,
		input logic [7:0] up, output logic [15:0] d);
		d = 16'hffff;
		#13;
		if (ld) begin
			captureStrobeN = 1'h0;
			// a clock pulse during load must change nothing
			#100 serialClk = 1'h1;
			#100 serialClk = 1'h0;
			#100 captureStrobeN = 1'h1;
		end
		#100 shiftGateN = !en;
		#100 d[0] = chainOut;
		for (int i = 0; i < n; i++) begin
			chainIn = (i < 8) ? up[i] : 1'h1;
			#100 serialClk = 1'h1;
			#200 serialClk = 1'h0;
			#200 if (i < 15) d[i+1] = chainOut;
		end
		#100 shiftGateN = 1'h1;
		chainIn = 1'h1;
	endtask : frame
endmodule : ids_host

/* File: dv/ids_serializer_tb_top.sv */
// Purpose: self-checking bench of the input debounce serializer
// Assumes: shortened timers, one tick is 20 clock cycles
// Notes:   expectations come from the select table and tick counts
`timescale 1ns/100ps
module ids_serializer_tb_top
	import ids_pkg::*;
;
	localparam int DS = 5;
	localparam int DL = 12;
	localparam int SF = 5;
	localparam int SR = 20;

	logic              ref_clk;
	logic              resetn;
	logic [NUM_CH-1:0] fieldInputs;
	logic              filterSelLo;
	logic              filterSelHi;
	ids_supply_type    supplyLevel;
	logic              supplyGood;
	logic              captureStrobeN;
	logic              serialClk;
	logic              shiftGateN;
	logic              chainIn;
	logic              chainOut;
	int                errors;
	int                comparisons;
	int                cycles;
	int                t;
	logic [31:0]       seed;
	logic [7:0]        cur;
	logic [7:0]        v;
	logic [1:0]        mode;
	logic [15:0]       got;

	ids_serializer #(
		.DEB_SHORT(DS),
		.DEB_LONG (DL),
		.SUP_FALL (SF),
		.SUP_RISE (SR)
	) dut (
		.ref_clk       (ref_clk),
		.resetn        (resetn),
		.fieldInputs   (fieldInputs),
		.filterSelLo   (filterSelLo),
		.filterSelHi   (filterSelHi),
		.supplyLevel   (supplyLevel),
		.supplyGood    (supplyGood),
		.captureStrobeN(captureStrobeN),
		.serialClk     (serialClk),
		.shiftGateN    (shiftGateN),
		.chainIn       (chainIn),
		.chainOut      (chainOut)
	);

	ids_host host (
		.captureStrobeN(captureStrobeN),
		.serialClk     (serialClk),
		.shiftGateN    (shiftGateN),
		.chainIn       (chainIn),
		.chainOut      (chainOut)
	);

	initial begin
		ref_clk = 1'h0;
		forever #25 ref_clk = !ref_clk;
	end

	// --------
	// helpers
	// --------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	function automatic int deb_ticks(input logic [1:0] sel);
		case (sel)
			2'h3: return DL;
			2'h2: return DS;
			default: return 0;
		endcase
	endfunction : deb_ticks

	task automatic next_rand(output logic [7:0] r);
		seed = xs(seed);
		r = seed[7:0];
	endtask : next_rand

	task automatic wt(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : wt

	task automatic check_frame(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask : check_frame

	task automatic check_flag(input logic g, input logic e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask : check_flag

	// gate high: output never moves, so the nine samples of an eight clock frame equal channel 0 and the rest stay ones
	task automatic frame_chk(input bit ld, input bit en, input int n,
		input logic [7:0] data);
		logic [7:0]  up;
		logic [15:0] exp;
		next_rand(up);
		host.frame(ld, en, n, up, got);
		exp = en ? {up, data} : {7'h7f, {9{data[0]}}};
		check_frame(got, exp);
		@(negedge ref_clk);
	endtask : frame_chk

	task automatic sup_step(input logic [2:0] l, input int w, input logic e);
		supplyLevel = l;
		wt(w);
		check_flag(supplyGood, e);
	endtask : sup_step

	task automatic finish_test();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	// a hang costs one mismatch and still reaches the report
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 12000) begin
			errors++;
			finish_test();
		end
	end

	// --------
	// sequence
	// --------
	initial begin
		errors = 0;
		comparisons = 0;
		cycles = 0;
		seed = 32'h0000ca73;
		resetn = 1'h0;
		fieldInputs = 8'h00;
		filterSelLo = 1'h1;
		filterSelHi = 1'h1;
		supplyLevel = 3'h0;
		cur = 8'h00;
		wt(12);
		check_flag(chainOut, 1'h1);
		check_flag(supplyGood, 1'h0);
		resetn = 1'h1;
		sup_step(3'h2, SR * 20 - 40, 1'h0);
		sup_step(3'h2, 80, 1'h1);
		sup_step(3'h4, SF * 20 - 40, 1'h1);
		sup_step(3'h4, 80, 1'h0);
		sup_step(3'h2, SR * 20 - 40, 1'h0);
		sup_step(3'h2, 80, 1'h1);
		sup_step(3'h4, SF * 10, 1'h1);
		sup_step(3'h2, SF * 40, 1'h1);
		sup_step(3'h5, 0, 1'h1);
		sup_step(3'h5, 5, 1'h0);
		sup_step(3'h2, SR * 20 - 40, 1'h0);
		sup_step(3'h2, 80, 1'h1);
		for (int m = 0; m < 4; m++) begin
			mode = 2'h3 - m[1:0];
			{filterSelHi, filterSelLo} = mode;
			t = deb_ticks(mode) * 20;
			wt(t + 40);
			next_rand(v);
			fieldInputs = v;
			if (t > 0)
				frame_chk(1'b1, 1'b1, 16, cur);
			wt(t + 60);
			frame_chk(1'b1, 1'b1, 16, v);
			cur = v;
			if (t > 0) begin
				fieldInputs = ~cur;
				wt(t / 2);
				fieldInputs = cur;
				wt(t + 60);
				frame_chk(1'b1, 1'b1, 16, cur);
			end
		end
		frame_chk(1'b1, 1'b0, 8, cur);
		next_rand(v);
		fieldInputs = v;
		wt(20);
		frame_chk(1'b0, 1'b1, 16, cur);
		frame_chk(1'b1, 1'b1, 16, v);
		finish_test();
	end
endmodule : ids_serializer_tb_top
